// [pit_pkg.sv]
// package: constants for the paired interval timer
package pit_pkg;

  // timer mode field encodings
  localparam logic [1:0] MODE_8BIT       = 2'h0;
  localparam logic [1:0] MODE_16BIT      = 2'h1;

  // lower clock select: external pin or prescaler taps
  localparam logic [1:0] LCLK_EXT        = 2'h0;
  localparam logic [1:0] LCLK_TAP1       = 2'h1;
  localparam logic [1:0] LCLK_TAP4       = 2'h2;
  localparam logic [1:0] LCLK_TAP16      = 2'h3;

  // upper clock select: lower match or prescaler taps
  localparam logic [1:0] UCLK_LMATCH     = 2'h0;
  localparam logic [1:0] UCLK_TAP1       = 2'h1;
  localparam logic [1:0] UCLK_TAP16      = 2'h2;
  localparam logic [1:0] UCLK_TAP256     = 2'h3;

  // flip-flop control field
  localparam logic [1:0] FFC_INVERT      = 2'h0;
  localparam logic [1:0] FFC_SET         = 2'h1;
  localparam logic [1:0] FFC_CLEAR       = 2'h2;
  localparam logic [1:0] FFC_NONE        = 2'h3;

  // reset values
  localparam logic [7:0] RST_COUNT       = 8'h00;
  localparam logic [7:0] RST_COMPARE     = 8'h00;
  localparam logic       RST_FF          = 1'b0;
  localparam logic       RST_FF_INV_EN   = 1'b0;
  localparam logic       RST_FF_SRC      = 1'b0;
  localparam logic       RST_CMP_EN      = 1'b1;

  // synchroniser depth for pin inputs
  localparam int         SYNC_STAGES     = 2;

endpackage

// [pit_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module pit_sync (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // data
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state        = state;
    next_state.meta   = async_in;
    // first stage read only by the second
    next_state.stable = state.meta;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule

// [pit_top.sv]
// paired 8/16-bit interval timer with toggle output
// Operation
// - two independent 8-bit timers in 8-bit mode
// - clock select: pin/taps lower, match/taps upper
// - each timer interrupts on its own 8-bit match
// - flip-flop toggles on match, drives pin
// - toggle source selectable lower or upper
// - control write clears, enables, selects source
// - upper counts lower matches when selected
// - mode 01 cascades into 16-bit timer
// - 16-bit upper clocked by lower overflow
// - lower compare low byte, upper high byte
// - low compare write suspends, high resumes
// - 16-bit lower match: no clear, no irq
// - joint 16-bit match clears both, upper irq
// - joint match toggles flip-flop if enabled
`timescale 1ns/1ps

module pit_top (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // run and mode control
  input  wire logic       lower_run_in,
  input  wire logic       upper_run_in,
  input  wire logic [1:0] timer_mode_field_in,
  input  wire logic [1:0] lower_clock_select_in,
  input  wire logic [1:0] upper_clock_select_field_in,
  // compare register writes
  input  wire logic       lower_compare_wr_in,
  input  wire logic       upper_compare_wr_in,
  input  wire logic [7:0] compare_wdata_in,
  // flip-flop control write
  input  wire logic       flipflop_control_wr_in,
  input  wire logic [1:0] flipflop_control_op_in,
  input  wire logic       flipflop_inv_enable_in,
  input  wire logic       flipflop_src_upper_in,
  // prescaler taps and pin
  input  wire logic       tap1_in,
  input  wire logic       tap4_in,
  input  wire logic       tap16_in,
  input  wire logic       tap256_in,
  input  wire logic       external_count_input_in,
  // status
  output logic [7:0]      lower_up_counter_out,
  output logic [7:0]      upper_up_counter_out,
  output logic            lower_timer_irq_out,
  output logic            upper_timer_irq_out,
  output logic            timer_output_pin_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] lower_compare_value;
    logic [7:0] upper_compare_value;
    logic       cmp_enable;
    logic       ff;
    logic       ff_inv_en;
    logic       ff_src_upper;
    logic [3:0] tap_prev;
    logic       pin_prev;
    logic       lmatch_prev;
    logic       umatch_prev;
    logic       jmatch_prev;
    logic       lower_irq;
    logic       upper_irq;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // pin and tap edges
  logic       ext_sync;
  logic [3:0] taps;
  logic [3:0] tap_rise;
  logic       pin_rise;

  // count ticks and mode
  logic       lower_tick;
  logic       upper_tick;
  logic       mode16;

  // counter status
  logic       lower_match;
  logic       upper_match;
  logic       lower_ovf;
  logic [7:0] lower_count;
  logic [7:0] upper_count;

  // compare hits gated by the compare enable
  logic       lower_hit;
  logic       upper_hit;
  logic       joint_hit;

  // single-cycle events
  logic       joint_clear;
  logic       lower_event;
  logic       upper_event;
  logic       joint_event;

  // interrupt and toggle decisions
  logic       lower_irq_set;
  logic       upper_irq_set;
  logic       toggle_src_event;
  logic       ff_toggle;

  function automatic logic rise(input logic now_v, input logic prev_v);
    rise = now_v && !prev_v;
  endfunction

  // ****************************************
  // clock sources
  // ****************************************
  pit_sync u_ext_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (external_count_input_in),
    .sync_out    (ext_sync)
  );

  // taps are same-domain prescaler levels; their rising edges are count ticks
  assign taps     = {tap256_in, tap16_in, tap4_in, tap1_in};
  assign tap_rise = taps & ~state.tap_prev;
  // the pin edge trails the pin by two cycles through the synchroniser
  assign pin_rise = rise(ext_sync, state.pin_prev);
  assign mode16   = (timer_mode_field_in == pit_pkg::MODE_16BIT);

  always_comb begin
    case (lower_clock_select_in)
      pit_pkg::LCLK_EXT:   lower_tick = pin_rise;
      pit_pkg::LCLK_TAP1:  lower_tick = tap_rise[0];
      pit_pkg::LCLK_TAP4:  lower_tick = tap_rise[1];
      pit_pkg::LCLK_TAP16: lower_tick = tap_rise[2];
      default:             lower_tick = 1'b0;
    endcase
  end

  always_comb begin
    if (mode16) begin
      upper_tick = lower_ovf;
    end else begin
      case (upper_clock_select_field_in)
        pit_pkg::UCLK_LMATCH: upper_tick = lower_event;
        pit_pkg::UCLK_TAP1:   upper_tick = tap_rise[0];
        pit_pkg::UCLK_TAP16:  upper_tick = tap_rise[2];
        pit_pkg::UCLK_TAP256: upper_tick = tap_rise[3];
        default:              upper_tick = 1'b0;
      endcase
    end
  end

  // ****************************************
  // counters
  // ****************************************
  // in 16-bit mode only the joint match clears, never the lower alone
  pit_unit #(.WIDTH(8)) u_lower (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .run_in            (lower_run_in),
    .tick_in           (lower_tick),
    .clear_in          (joint_clear),
    .clear_on_match_in (!mode16),
    .compare_in        (state.lower_compare_value),
    .count_out         (lower_count),
    .match_out         (lower_match),
    .overflow_out      (lower_ovf)
  );

  pit_unit #(.WIDTH(8)) u_upper (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .run_in            (upper_run_in),
    .tick_in           (upper_tick),
    .clear_in          (joint_clear),
    .clear_on_match_in (!mode16),
    .compare_in        (state.upper_compare_value),
    .count_out         (upper_count),
    .match_out         (upper_match),
    .overflow_out      ()
  );

  // ****************************************
  // match events
  // ****************************************
  // a low byte write in 16-bit mode masks every hit until the high byte
  assign lower_hit   = lower_match && state.cmp_enable;
  assign upper_hit   = upper_match && state.cmp_enable;
  // 16-bit compare: low byte and high byte together
  assign joint_hit   = lower_hit && upper_hit;

  // events fire once on entry to the match value, not every cycle it is held
  assign lower_event = rise(lower_hit, state.lmatch_prev);
  assign upper_event = rise(upper_hit, state.umatch_prev);
  assign joint_event = mode16 && rise(joint_hit, state.jmatch_prev);
  assign joint_clear = joint_event;

  // ****************************************
  // interrupts
  // ****************************************
  // 16-bit mode: the lower match alone never interrupts
  always_comb begin
    if (mode16) begin
      lower_irq_set = 1'b0;
      upper_irq_set = joint_event;
    end else begin
      lower_irq_set = lower_event;
      upper_irq_set = upper_event;
    end
  end

  // ****************************************
  // flip-flop toggle source
  // ****************************************
  // 16-bit mode ignores the source select: only the joint match inverts
  always_comb begin
    if (mode16) begin
      toggle_src_event = joint_event;
    end else if (state.ff_src_upper) begin
      toggle_src_event = upper_event;
    end else begin
      toggle_src_event = lower_event;
    end
  end

  assign ff_toggle = state.ff_inv_en && toggle_src_event;

  // ****************************************
  // registers
  // ****************************************
  always_comb begin
    next_state             = state;
    next_state.tap_prev    = taps;
    next_state.pin_prev    = ext_sync;
    next_state.lmatch_prev = lower_hit;
    next_state.umatch_prev = upper_hit;
    next_state.jmatch_prev = joint_hit;
    next_state.lower_irq   = lower_irq_set;
    next_state.upper_irq   = upper_irq_set;

    if (lower_compare_wr_in) begin
      next_state.lower_compare_value = compare_wdata_in;
      if (mode16) begin
        next_state.cmp_enable = 1'b0;
      end
    end
    if (upper_compare_wr_in) begin
      next_state.upper_compare_value = compare_wdata_in;
      next_state.cmp_enable          = 1'b1;
    end

    if (flipflop_control_wr_in) begin
      // one write sets op, enable and source together
      next_state.ff_inv_en    = flipflop_inv_enable_in;
      next_state.ff_src_upper = flipflop_src_upper_in;
      case (flipflop_control_op_in)
        pit_pkg::FFC_INVERT: next_state.ff = !state.ff;
        pit_pkg::FFC_SET:    next_state.ff = 1'b1;
        pit_pkg::FFC_CLEAR:  next_state.ff = 1'b0;
        // a no-op write must not swallow a toggle of the same cycle
        default:             next_state.ff = state.ff ^ ff_toggle;
      endcase
    end else if (ff_toggle) begin
      next_state.ff = !state.ff;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state                     <= '0;
      state.lower_compare_value <= pit_pkg::RST_COMPARE;
      state.upper_compare_value <= pit_pkg::RST_COMPARE;
      state.cmp_enable          <= pit_pkg::RST_CMP_EN;
      state.ff                  <= pit_pkg::RST_FF;
      state.ff_inv_en           <= pit_pkg::RST_FF_INV_EN;
      state.ff_src_upper        <= pit_pkg::RST_FF_SRC;
      // no stale match history may look like a fresh entry after reset
      state.tap_prev            <= 4'h0;
      state.pin_prev            <= 1'b0;
      state.lmatch_prev         <= 1'b0;
      state.umatch_prev         <= 1'b0;
      state.jmatch_prev         <= 1'b0;
      state.lower_irq           <= 1'b0;
      state.upper_irq           <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // counters come straight from the unit registers
  assign lower_up_counter_out = lower_count;
  assign upper_up_counter_out = upper_count;
  assign lower_timer_irq_out  = state.lower_irq;
  assign upper_timer_irq_out  = state.upper_irq;
  assign timer_output_pin_out = state.ff;

endmodule

// [pit_top_properties.sv]
// assertion checker for the paired interval timer ports
`timescale 1ns/1ps

module pit_top_checker (
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  // controls
  input wire logic       lower_run_in,
  input wire logic       upper_run_in,
  input wire logic [1:0] timer_mode_field_in,
  input wire logic       flipflop_control_wr_in,
  input wire logic [1:0] flipflop_control_op_in,
  // status
  input wire logic [7:0] lower_up_counter_out,
  input wire logic [7:0] upper_up_counter_out,
  input wire logic       lower_timer_irq_out,
  input wire logic       upper_timer_irq_out,
  input wire logic       timer_output_pin_out
);
  // ******
  // properties
  // ******
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic       wide;
  logic [7:0] lo;
  logic [7:0] hi;
  assign wide = timer_mode_field_in == pit_pkg::MODE_16BIT;
  assign lo = lower_up_counter_out;
  assign hi = upper_up_counter_out;

  sequence s_joint;
    wide && $past(wide) ##0 upper_timer_irq_out;
  endsequence

  sequence s_ff_clr;
    flipflop_control_wr_in && flipflop_control_op_in == pit_pkg::FFC_CLEAR;
  endsequence

  AST_LO_STOP: assert property (!lower_run_in |=> lo == 8'h00)
    else $error("lower count not held");
  AST_HI_STOP: assert property (!upper_run_in |=> hi == 8'h00)
    else $error("upper count not held");
  AST_LO_STEP: assert property ($changed(lo) |-> lo == $past(lo) + 8'h01 || lo == 8'h00)
    else $error("lower count jumped");
  // the carry lands on the same edge as the wrap; a wrap two edges back is allowed as well
  AST_CARRY: assert property (wide && $past(wide) && $changed(hi)
    |-> hi == 8'h00 || $past(lo) == 8'hff || $past(lo, 2) == 8'hff)
    else $error("upper moved without carry");
  AST_NO_LO_IRQ: assert property (wide && $past(wide) |-> !lower_timer_irq_out)
    else $error("lower irq in wide mode");
  AST_JOINT: assert property (s_joint |-> lo == 8'h00 && hi == 8'h00)
    else $error("counts not cleared on joint match");
  AST_PIN: assert property ($changed(timer_output_pin_out)
    |-> $past(flipflop_control_wr_in) || lower_timer_irq_out || upper_timer_irq_out)
    else $error("pin moved without cause");
  AST_FF_CLR: assert property (s_ff_clr |=> !timer_output_pin_out)
    else $error("pin not cleared");
  AST_IRQ_ONE: assert property (upper_timer_irq_out |=> !upper_timer_irq_out)
    else $error("upper irq longer than a cycle");
endmodule

bind pit_top pit_top_checker u_pit_top_checker (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .lower_run_in(lower_run_in),
  .upper_run_in(upper_run_in),
  .timer_mode_field_in(timer_mode_field_in),
  .flipflop_control_wr_in(flipflop_control_wr_in),
  .flipflop_control_op_in(flipflop_control_op_in),
  .lower_up_counter_out(lower_up_counter_out),
  .upper_up_counter_out(upper_up_counter_out),
  .lower_timer_irq_out(lower_timer_irq_out),
  .upper_timer_irq_out(upper_timer_irq_out),
  .timer_output_pin_out(timer_output_pin_out)
);

// [pit_unit.sv]
// one 8-bit up counter with comparator
`timescale 1ns/1ps

module pit_unit #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  // control
  input  wire logic             run_in,
  input  wire logic             tick_in,
  input  wire logic             clear_in,
  input  wire logic             clear_on_match_in,
  input  wire logic [WIDTH-1:0] compare_in,
  // status
  output logic [WIDTH-1:0]      count_out,
  output logic                  match_out,
  output logic                  overflow_out
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             pend_clear;
  } unit_state_t;

  unit_state_t state;
  unit_state_t next_state;

  always_comb begin
    next_state = state;
    if (!run_in || clear_in) begin
      next_state.count      = '0;
      next_state.pend_clear = 1'b0;
    end else if (tick_in) begin
      // clear on the tick after a match keeps the compare value for one full period
      if (state.pend_clear) begin
        next_state.count = '0;
      end else begin
        next_state.count = state.count + 1'b1;
      end
      next_state.pend_clear = clear_on_match_in && (next_state.count == compare_in);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count_out    = state.count;
  // level while counter equals compare; the top turns it into events
  assign match_out    = run_in && (state.count == compare_in);
  assign overflow_out = run_in && tick_in && (state.count == {WIDTH{1'b1}});

endmodule

// [tb.sv]
// self-checking bench for the paired interval timer
`timescale 1ns/1ps

module tb;
  // ******
  // stimulus, tasks and scenarios
  // ******
  logic       clk = 1'b0;
  logic       rst, lrun, urun, lwr, uwr, fwr, finv, fsrc, lirq, uirq, pin;
  logic [1:0] mode, lsel, usel, fop;
  logic [7:0] wd, lcnt, ucnt;
  logic [8:0] div = 9'h000;
  int         err_total = 0;
  int         checks = 0;

  pit_top u_pit_top (
    .core_clk_in(clk), .rst_in(rst), .lower_run_in(lrun), .upper_run_in(urun),
    .timer_mode_field_in(mode), .lower_clock_select_in(lsel),
    .upper_clock_select_field_in(usel), .lower_compare_wr_in(lwr),
    .upper_compare_wr_in(uwr), .compare_wdata_in(wd),
    .flipflop_control_wr_in(fwr), .flipflop_control_op_in(fop),
    .flipflop_inv_enable_in(finv), .flipflop_src_upper_in(fsrc),
    .tap1_in(div[0]), .tap4_in(div[2]), .tap16_in(div[4]), .tap256_in(div[8]),
    .external_count_input_in(div[1]), .lower_up_counter_out(lcnt),
    .upper_up_counter_out(ucnt), .lower_timer_irq_out(lirq),
    .upper_timer_irq_out(uirq), .timer_output_pin_out(pin)
  );

  always #5 clk = ~clk;
  // divider bits as taps: ticks every 2, 8, 32, 512 cycles, pin every 4
  always @(posedge clk) div <= #1 div + 9'h001;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wcmp(input logic h, input logic [7:0] v);
    wd = v;
    lwr = ~h;
    uwr = h;
    cyc(1);
    lwr = 1'b0;
    uwr = 1'b0;
    cyc(1);
  endtask

  task automatic ffc(input logic [1:0] op, input logic inv, input logic src);
    {fop, finv, fsrc} = {op, inv, src};
    fwr = 1'b1;
    cyc(1);
    fwr = 1'b0;
    cyc(1);
  endtask

  task automatic halt(input logic [1:0] m);
    {lrun, urun} = 2'h0;
    cyc(2);
    mode = m;
  endtask

  // stopping before any reprogramming keeps the counters from racing the writes
  task automatic go;
    {lrun, urun} = 2'h3;
  endtask

  // first pass syncs to an event, second counts cycles to the next one
  task automatic gap(input int s, input int lim, output int n);
    logic p;
    repeat (2) begin
      n = 0;
      p = pin;
      do begin
        cyc(1);
        n++;
      end while (n < lim && (s == 2 ? pin === p : (s == 0 ? lirq : uirq) !== 1'b1));
    end
  endtask

  task automatic t_eight;
    int n;
    halt(pit_pkg::MODE_8BIT);
    {lsel, usel} = {pit_pkg::LCLK_TAP1, pit_pkg::UCLK_TAP1};
    wcmp(1'b0, 8'h02);
    wcmp(1'b1, 8'h03);
    go();
    gap(0, 100, n);
    chk("lower irq gap", 6, n);
    gap(1, 100, n);
    chk("upper irq gap", 8, n);
    halt(pit_pkg::MODE_8BIT);
    chk("stopped count", 0, lcnt);
    chk("stopped upper count", 0, ucnt);
  endtask

  task automatic t_clk;
    int n, i;
    int le[4] = '{8, 4, 16, 64};
    int ue[4] = '{16, 4, 64, 1024};
    wcmp(1'b0, 8'h01);
    wcmp(1'b1, 8'h01);
    for (i = 0; i < 4; i++) begin
      halt(pit_pkg::MODE_8BIT);
      {lsel, usel} = {i[1:0], i[1:0]};
      go();
      gap(0, 200, n);
      chk("lower source gap", le[i], n);
      gap(1, 2500, n);
      chk("upper source gap", ue[i], n);
    end
  endtask

  task automatic t_flop;
    int n;
    logic p;
    halt(pit_pkg::MODE_8BIT);
    {lsel, usel} = {pit_pkg::LCLK_TAP1, pit_pkg::UCLK_TAP1};
    wcmp(1'b0, 8'h02);
    wcmp(1'b1, 8'h03);
    ffc(pit_pkg::FFC_SET, 1'b0, 1'b0);
    chk("pin set", 1, pin);
    ffc(pit_pkg::FFC_CLEAR, 1'b1, 1'b1);
    chk("pin cleared", 0, pin);
    go();
    gap(2, 100, n);
    chk("upper half period", 8, n);
    halt(pit_pkg::MODE_8BIT);
    p = pin;
    ffc(pit_pkg::FFC_INVERT, 1'b1, 1'b0);
    chk("pin inverted", {31'h0, ~p}, pin);
    go();
    gap(2, 100, n);
    chk("lower half period", 6, n);
    halt(pit_pkg::MODE_8BIT);
    ffc(pit_pkg::FFC_NONE, 1'b0, 1'b0);
    p = pin;
    go();
    cyc(40);
    chk("pin held", {31'h0, p}, pin);
  endtask

  task automatic t_wide;
    int n, k, c;
    halt(pit_pkg::MODE_16BIT);
    {lsel, usel} = {pit_pkg::LCLK_TAP1, pit_pkg::UCLK_TAP256};
    wcmp(1'b0, 8'h03);
    wcmp(1'b1, 8'h01);
    ffc(pit_pkg::FFC_CLEAR, 1'b1, 1'b1);
    go();
    gap(1, 700, n);
    chk("wide irq gap", 518, n);
    // 257 ticks after the joint clear: 16-bit count 0x0101
    cyc(513);
    chk("wide low count", 1, lcnt);
    chk("wide high count", 1, ucnt);
    gap(2, 700, n);
    chk("wide pin gap", 518, n);
    halt(pit_pkg::MODE_16BIT);
    wcmp(1'b0, 8'h02);
    go();
    c = 0;
    for (k = 0; k < 600; k++) begin
      cyc(1);
      c += (uirq === 1'b1 || lirq === 1'b1);
    end
    chk("suspended irqs", 0, c);
    halt(pit_pkg::MODE_16BIT);
    wcmp(1'b1, 8'h01);
    go();
    gap(1, 700, n);
    chk("resumed irq gap", 516, n);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    {lrun, urun, lwr, uwr, fwr, finv, fsrc} = 7'h00;
    {mode, lsel, usel, fop} = 8'h00;
    wd = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_eight();
    t_clk();
    t_flop();
    t_wide();
    tally_and_finish();
  end
endmodule
